// File: tb_temp_sensor_mode_and_alert_ctrl.sv
`timescale 1ns/10ps
module tb_temp_sensor_mode_and_alert_ctrl;
  import tsm_pkg::*;
  localparam int         ODR_B    = 256;
  localparam int         CONV     = 800;
  localparam int         PWR_WAIT = 100;
  // identity value is arbitrary
  localparam logic [7:0] ID       = 8'h3C;
  logic        core_clk, rst_n, scl, sda_m, sda_wire, sel, ack;
  logic        sda_out, sda_oe, alert_out, alert_oe, chain_enable;
  logic [15:0] sense_data;
  logic [7:0]  d;
  int          miscompares, total_checks, gap, since_clr;

  assign sda_wire = sda_m & ~sda_oe;

  tsm_sensor_ctrl #(.ODR_BASE(ODR_B), .CONV_CYC(CONV), .ID_VALUE(ID)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_in(sel), .alert_out(alert_out),
    .alert_oe(alert_oe), .chain_enable(chain_enable), .sense_data(sense_data));

  tsm_host_model host (.core_clk(core_clk), .sda_wire(sda_wire), .scl(scl), .sda_m(sda_m));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // cycles the alert stayed released before it came back
  always @(posedge core_clk) begin
    if (alert_oe === 1'b1 && since_clr > 0) gap <= since_clr;
    since_clr <= (alert_oe === 1'b1) ? 0 : since_clr + 1;
  end

  // ==========================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp1(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] e, input string n);
    host.rd(a, d);
    cmp8(n, e, d);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #600_000;
    miscompares++;
    finish_test();
  end

  // ==========================================================
  // tests
  initial begin
    rst_n = 1'b0;
    sel = 1'b1;
    sense_data = 16'h0000;
    miscompares = 0;
    total_checks = 0;
    cyc(3);
    rst_n = 1'b1;
    cmp1("chain_rst", 1'b0, chain_enable);
    cmp1("alert_rst", 1'b0, alert_oe);
    cyc(PWR_WAIT);
    chk(ADDR_ID, ID, "id");
    chk(ADDR_CTRL, 8'h00, "ctrl_rst");
    chk(ADDR_LO_LIM, 8'h00, "lo_rst");
    host.start();
    host.tx(8'h7E, ack);
    host.stop();
    cmp1("foreign_ack", 1'b0, ack);
    // single conversion
    sense_data = 16'h0E42;
    host.wr(8'h0C, 8'h02);
    chk(8'h0C, 8'h00, "unmapped");
    host.wr(ADDR_CTRL, 8'h01);
    chk(ADDR_STATUS, 8'h01, "busy");
    cmp1("chain_on", 1'b1, chain_enable);
    for (int i = 0; i < CONV && chain_enable !== 1'b0; i++) cyc(1);
    cmp1("chain_off", 1'b0, chain_enable);
    chk(ADDR_STATUS, 8'h00, "busy_done");
    chk(ADDR_CTRL, 8'h00, "trig_clr");
    sense_data = 16'h7FFF;
    cyc(CONV);
    chk(ADDR_DATA_LO, 8'h42, "data_lo");
    chk(ADDR_DATA_HI, 8'h0E, "data_hi");
    cmp1("pd_chain", 1'b0, chain_enable);
    // threshold boundary: 65 maps to 128 counts
    host.wr(ADDR_HI_LIM, 8'h41);
    chk(ADDR_HI_LIM, 8'h41, "hi_rw");
    for (int k = 0; k < 2; k++) begin
      sense_data = 16'd128 + 16'(k);
      host.wr(ADDR_CTRL, 8'h34);
      cyc(2 * ODR_B);
      cmp1("alert_edge", k[0], alert_oe);
      chk(ADDR_STATUS, {6'h00, k[0], 1'b0}, "over");
      host.wr(ADDR_CTRL, 8'h00);
    end
    // every rate: alert returns within one period of a status read
    sense_data = 16'd1000;
    for (int r = 0; r < 4; r++) begin
      host.wr(ADDR_CTRL, 8'h00);
      host.wr(ADDR_CTRL, 8'h04 | 8'(r << 4));
      cyc(8 * ODR_B);
      host.rd(ADDR_STATUS, d);
      for (int i = 0; i < 8 * ODR_B && alert_oe !== 1'b1; i++) cyc(1);
      // gap is taken one edge after the alert returns
      cyc(1);
      cmp1("rate_gap", 1'b1, alert_oe === 1'b1 && gap <= ODR_B * (8 >> r));
    end
    sense_data = 16'd0;
    cyc(2 * ODR_B);
    cmp1("alert_held", 1'b1, alert_oe);
    cmp1("alert_drive", 1'b0, alert_out);
    cmp1("sda_drive", 1'b0, sda_out);
    chk(ADDR_STATUS, 8'h02, "over_kept");
    cyc(2 * ODR_B);
    cmp1("alert_free", 1'b0, alert_oe);
    chk(ADDR_STATUS, 8'h00, "flags_clr");
    // under limit, then both limits zero
    host.wr(ADDR_CTRL, 8'h00);
    host.wr(ADDR_HI_LIM, 8'hC8);
    host.wr(ADDR_LO_LIM, 8'h46);
    sense_data = 16'd100;
    host.wr(ADDR_CTRL, 8'h34);
    cyc(2 * ODR_B);
    chk(ADDR_STATUS, 8'h04, "under");
    host.wr(ADDR_CTRL, 8'h00);
    host.wr(ADDR_HI_LIM, 8'h00);
    host.wr(ADDR_LO_LIM, 8'h00);
    host.rd(ADDR_STATUS, d);
    sense_data = 16'hEC78;
    host.wr(ADDR_CTRL, 8'h34);
    cyc(2 * ODR_B);
    cmp1("alert_dis", 1'b0, alert_oe);
    chk(ADDR_STATUS, 8'h00, "flags_dis");
    // hold until both bytes are read
    host.wr(ADDR_CTRL, 8'h00);
    sense_data = 16'h1234;
    host.wr(ADDR_CTRL, 8'h74);
    cyc(2 * ODR_B);
    chk(ADDR_DATA_LO, 8'h34, "hold_lo");
    sense_data = 16'h5678;
    cyc(2 * ODR_B);
    chk(ADDR_DATA_HI, 8'h12, "hold_hi");
    cyc(2 * ODR_B);
    chk(ADDR_DATA_LO, 8'h78, "run_lo");
    chk(ADDR_DATA_HI, 8'h56, "run_hi");
    host.wr(ADDR_CTRL, 8'h00);
    sense_data = 16'h0000;
    cyc(2 * ODR_B);
    chk(ADDR_DATA_LO, 8'h78, "pd_lo");
    cmp1("pd_chain2", 1'b0, chain_enable);
    // pointer steps after each data byte when auto-increment is set
    host.wr(ADDR_CTRL, 8'h08);
    host.start();
    host.tx(8'h70, ack);
    host.tx(ADDR_HI_LIM, ack);
    host.tx(8'h11, ack);
    host.tx(8'h22, ack);
    host.stop();
    cmp1("wr_ack", 1'b1, ack);
    chk(ADDR_HI_LIM, 8'h11, "inc_hi");
    chk(ADDR_LO_LIM, 8'h22, "inc_lo");
    finish_test();
  end
endmodule

// File: tsm_host_model.sv
`timescale 1ns/10ps
// ==========================================================
// two-wire bus master: clock driven push-pull, data open-drain and pulled up
module tsm_host_model (
  input  wire logic core_clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // all pin changes land just after a core clock edge
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // serves as start and repeated start
  task automatic start();
    sda_m = 1'b1;
    // a full low phase lets the slave drop its acknowledge first
    wt(4);
    scl = 1'b1;
    wt(4);
    sda_m = 1'b0;
    wt(4);
    scl = 1'b0;
  endtask

  task automatic stop();
    wt(2);
    sda_m = 1'b0;
    wt(2);
    scl = 1'b1;
    wt(4);
    sda_m = 1'b1;
    wt(4);
  endtask

  // data set mid low phase, sampled at the end of the high phase
  task automatic clk_bit(input logic b, output logic s);
    wt(2);
    sda_m = b;
    wt(2);
    scl = 1'b1;
    wt(4);
    s = sda_wire;
    scl = 1'b0;
  endtask

  task automatic tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask

  // single byte read ends with a no-acknowledge
  task automatic rx(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(1'b1, s);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k;
    start();
    tx(8'h70, k);
    tx(a, k);
    tx(d, k);
    stop();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    tx(8'h70, k);
    tx(a, k);
    start();
    tx(8'h71, k);
    rx(d);
    stop();
  endtask
endmodule

// File: tsm_pkg.sv
package tsm_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_ID      = 8'h01;
  localparam logic [7:0] ADDR_HI_LIM  = 8'h02;
  localparam logic [7:0] ADDR_LO_LIM  = 8'h03;
  localparam logic [7:0] ADDR_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h05;
  localparam logic [7:0] ADDR_DATA_LO = 8'h06;
  localparam logic [7:0] ADDR_DATA_HI = 8'h07;
  // ==========================================================
  // field positions and reset values
  localparam int         CTRL_TRIG_BIT    = 0;
  localparam int         CTRL_RUN_BIT     = 2;
  localparam int         CTRL_AUTOINC_BIT = 3;
  localparam int         CTRL_RATE_LSB    = 4;
  localparam int         CTRL_HOLD_BIT    = 6;
  localparam logic [7:0] CTRL_WR_MASK     = 8'h7D;
  localparam int         STAT_BUSY_BIT    = 0;
  localparam int         STAT_OVER_BIT    = 1;
  localparam int         STAT_UNDER_BIT   = 2;
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam logic [7:0] LIMIT_RESET      = 8'h00;
  localparam logic [15:0] DATA_RESET      = 16'h0000;
  // identity value is arbitrary
  localparam logic [7:0] ID_VALUE_DEFAULT = 8'h5A;
  // ==========================================================
  // serial bus addresses, selected by the address pin
  localparam logic [6:0] BUS_ADDR_SEL_HI = 7'h38;
  localparam logic [6:0] BUS_ADDR_SEL_LO = 7'h3F;
  // ==========================================================
  // threshold scale: (value - 63) * 0.64 degC, result lsb 0.01 degC
  localparam logic [8:0] THR_OFFSET    = 9'h03F;
  localparam int         THR_STEP_LOG2 = 6;
  // ==========================================================
  // timing
  localparam int CLK_HZ          = 125000000;
  localparam int ODR_MAX_HZ      = 200;
  localparam int CONV_TIME_US    = 1000;
  localparam int ODR_BASE_CYCLES = CLK_HZ / ODR_MAX_HZ;
  localparam int CONV_CYCLES     = (CLK_HZ / 1000000) * CONV_TIME_US;
  localparam int CNT_W           = 24;
  // ==========================================================
  typedef enum logic [2:0] {
    M_OFF    = 3'b001,
    M_SINGLE = 3'b010,
    M_RUN    = 3'b100
  } tsm_mode_t;
  typedef enum logic [4:0] {
    I_IDLE = 5'b00001,
    I_ADDR = 5'b00010,
    I_REGA = 5'b00100,
    I_WR   = 5'b01000,
    I_RD   = 5'b10000
  } tsm_bus_t;
endpackage

// File: tsm_sensor_ctrl.sv
// Function
// - identity register returns fixed value
// - run bit zero means power-down, no conversions
// - power-down keeps data, bus stays usable
// - reset enters power-down
// - trigger in power-down makes one conversion
// - busy reads one during single conversion
// - data frozen until next trigger
// - run bit one samples repeatedly
// - rate field picks 25/50/100/200 Hz
// - 16-bit signed result, low at 6
// - one count is 0.01 degC
// - thresholds at 2,3; both zero disables
// - threshold equals (value-63) times 0.64
// - alert held low after limit crossing
// - status read releases alert, re-asserts later
// - limit flags clear on status read
// - busy reads zero in continuous mode
// - hold option freezes data until read
`timescale 1ns/10ps
module tsm_sensor_ctrl
  import tsm_pkg::*;
#(
  parameter int         ODR_BASE = ODR_BASE_CYCLES,
  parameter int         CONV_CYC = CONV_CYCLES,
  parameter logic [7:0] ID_VALUE = ID_VALUE_DEFAULT
) (
  input  logic        core_clk,
  input  logic        rst_n,
  input  logic        scl_in,
  input  logic        sda_in,
  output logic        sda_out,
  output logic        sda_oe,
  input  logic        addr_sel_in,
  output logic        alert_out,
  output logic        alert_oe,
  output logic        chain_enable,
  input  logic [15:0] sense_data
);
  // ==========================================================
  // declarations
  logic [1:0]       scl_sync;
  logic [1:0]       sda_sync;
  logic [1:0]       sel_sync;
  logic             scl_d;
  logic             sda_d;
  logic             scl_rise;
  logic             scl_fall;
  logic             bus_start;
  logic             bus_stop;
  tsm_bus_t         bus_st;
  logic [3:0]       bit_cnt;
  logic             ack_ph;
  logic             rw_bit;
  logic             nack;
  logic [7:0]       shreg;
  logic [7:0]       tx;
  logic [7:0]       ptr;
  logic             wr_pulse;
  logic [7:0]       wr_addr;
  logic [7:0]       wr_data;
  logic             rd_pulse;
  logic [7:0]       rd_addr;
  logic [7:0]       rd_byte;
  logic [7:0]       ctrl;
  logic [7:0]       hi_lim;
  logic [7:0]       lo_lim;
  tsm_mode_t        mode;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] period_last;
  logic             conv_done;
  logic [15:0]      temp;
  logic             hold_lock;
  logic             over_flag;
  logic             under_flag;
  logic             status_clr;
  logic             lim_on;
  logic             over_now;
  logic             under_now;
  logic [6:0]       dev_addr;

  // threshold register mapped into result scale
  function automatic logic signed [16:0] thr_scale(input logic [7:0] v);
    logic [8:0] diff;
    diff = {1'b0, v} - THR_OFFSET;
    return {{2{diff[8]}}, diff, {THR_STEP_LOG2{1'b0}}};
  endfunction

  // ==========================================================
  // pin synchronisers and edge detection
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      sel_sync <= 2'b00;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      sel_sync <= {sel_sync[0], addr_sel_in};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  assign scl_rise  = scl_sync[1] & ~scl_d;
  assign scl_fall  = ~scl_sync[1] & scl_d;
  assign bus_start = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign bus_stop  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  assign dev_addr  = sel_sync[1] ? BUS_ADDR_SEL_HI : BUS_ADDR_SEL_LO;

  // ==========================================================
  // register read mux
  always_comb begin
    unique case (ptr)
      ADDR_ID:      rd_byte = ID_VALUE;
      ADDR_HI_LIM:  rd_byte = hi_lim;
      ADDR_LO_LIM:  rd_byte = lo_lim;
      ADDR_CTRL:    rd_byte = ctrl;
      ADDR_STATUS:  rd_byte = {5'h00, under_flag, over_flag, mode == M_SINGLE};
      ADDR_DATA_LO: rd_byte = temp[7:0];
      ADDR_DATA_HI: rd_byte = temp[15:8];
      default:      rd_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // serial bus slave
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_st   <= I_IDLE;
      bit_cnt  <= 4'h0;
      ack_ph   <= 1'b0;
      rw_bit   <= 1'b0;
      nack     <= 1'b0;
      shreg    <= 8'h00;
      tx       <= 8'h00;
      ptr      <= 8'h00;
      sda_oe   <= 1'b0;
      sda_out  <= 1'b0;
      wr_pulse <= 1'b0;
      wr_addr  <= 8'h00;
      wr_data  <= 8'h00;
      rd_pulse <= 1'b0;
      rd_addr  <= 8'h00;
    end else begin
      sda_out  <= 1'b0;
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      if (bus_start) begin
        bus_st  <= I_ADDR;
        bit_cnt <= 4'h0;
        ack_ph  <= 1'b0;
        sda_oe  <= 1'b0;
      end else if (bus_stop) begin
        bus_st <= I_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise && bus_st != I_IDLE) begin
        if (bit_cnt < 4'h8) begin
          shreg   <= {shreg[6:0], sda_sync[1]};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (bus_st == I_RD) begin
          nack    <= sda_sync[1];
          bit_cnt <= 4'h9;
        end
      end else if (scl_fall) begin
        unique case (bus_st)
          I_IDLE: ;
          I_RD: begin
            if (bit_cnt < 4'h8) begin
              sda_oe <= ~tx[6];
              tx     <= {tx[6:0], 1'b0};
            end else if (bit_cnt == 4'h8) begin
              sda_oe <= 1'b0;
            end else if (!nack) begin
              bit_cnt  <= 4'h0;
              tx       <= rd_byte;
              sda_oe   <= ~rd_byte[7];
              rd_pulse <= 1'b1;
              rd_addr  <= ptr;
              ptr      <= ctrl[CTRL_AUTOINC_BIT] ? ptr + 8'h01 : ptr;
            end else begin
              bus_st <= I_IDLE;
              sda_oe <= 1'b0;
            end
          end
          default: begin
            if (bit_cnt == 4'h8 && !ack_ph) begin
              ack_ph <= 1'b1;
              if (bus_st == I_ADDR) begin
                if (shreg[7:1] == dev_addr) begin
                  sda_oe <= 1'b1;
                  rw_bit <= shreg[0];
                end else begin
                  bus_st <= I_IDLE;
                end
              end else if (bus_st == I_REGA) begin
                ptr    <= shreg;
                sda_oe <= 1'b1;
              end else begin
                wr_pulse <= 1'b1;
                wr_addr  <= ptr;
                wr_data  <= shreg;
                sda_oe   <= 1'b1;
              end
            end else if (ack_ph) begin
              ack_ph  <= 1'b0;
              bit_cnt <= 4'h0;
              sda_oe  <= 1'b0;
              if (bus_st == I_ADDR && rw_bit) begin
                bus_st   <= I_RD;
                tx       <= rd_byte;
                sda_oe   <= ~rd_byte[7];
                rd_pulse <= 1'b1;
                rd_addr  <= ptr;
                ptr      <= ctrl[CTRL_AUTOINC_BIT] ? ptr + 8'h01 : ptr;
              end else if (bus_st == I_ADDR) begin
                bus_st <= I_REGA;
              end else if (bus_st == I_REGA) begin
                bus_st <= I_WR;
              end else if (ctrl[CTRL_AUTOINC_BIT]) begin
                ptr <= ptr + 8'h01;
              end
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // control and threshold registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl   <= CTRL_RESET;
      hi_lim <= LIMIT_RESET;
      lo_lim <= LIMIT_RESET;
    end else begin
      if (conv_done && mode == M_SINGLE) begin
        ctrl[CTRL_TRIG_BIT] <= 1'b0;
      end
      if (wr_pulse && wr_addr == ADDR_CTRL) begin
        ctrl <= wr_data & CTRL_WR_MASK;
      end
      if (wr_pulse && wr_addr == ADDR_HI_LIM) begin
        hi_lim <= wr_data;
      end
      if (wr_pulse && wr_addr == ADDR_LO_LIM) begin
        lo_lim <= wr_data;
      end
    end
  end

  // ==========================================================
  // operating mode and conversion timing
  assign period_last = CNT_W'((ODR_BASE << (2'd3 - ctrl[CTRL_RATE_LSB+:2])) - 1);
  assign conv_done   = (mode == M_SINGLE && cnt == CNT_W'(CONV_CYC - 1))
                     | (mode == M_RUN && ctrl[CTRL_RUN_BIT] && cnt == period_last);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode         <= M_OFF;
      cnt          <= '0;
      chain_enable <= 1'b0;
    end else begin
      chain_enable <= (mode != M_OFF);
      unique case (mode)
        M_OFF: begin
          cnt <= '0;
          if (ctrl[CTRL_RUN_BIT]) begin
            mode <= M_RUN;
          end else if (ctrl[CTRL_TRIG_BIT]) begin
            mode <= M_SINGLE;
          end
        end
        M_SINGLE: begin
          cnt <= cnt + 1'b1;
          if (conv_done) begin
            mode <= M_OFF;
          end
        end
        M_RUN: begin
          cnt <= conv_done ? '0 : cnt + 1'b1;
          if (!ctrl[CTRL_RUN_BIT]) begin
            mode <= M_OFF;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // result, limit flags and alert pin
  assign status_clr = rd_pulse && rd_addr == ADDR_STATUS;
  assign lim_on     = (hi_lim != 8'h00) || (lo_lim != 8'h00);
  assign over_now   = lim_on && $signed({sense_data[15], sense_data}) > thr_scale(hi_lim);
  assign under_now  = lim_on && $signed({sense_data[15], sense_data}) < thr_scale(lo_lim);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      temp      <= DATA_RESET;
      hold_lock <= 1'b0;
    end else begin
      if (conv_done && !(ctrl[CTRL_HOLD_BIT] && hold_lock)) begin
        temp <= sense_data;
      end
      if (rd_pulse && rd_addr == ADDR_DATA_LO && ctrl[CTRL_HOLD_BIT]) begin
        hold_lock <= 1'b1;
      end else if ((rd_pulse && rd_addr == ADDR_DATA_HI) || !ctrl[CTRL_HOLD_BIT]) begin
        hold_lock <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      over_flag  <= 1'b0;
      under_flag <= 1'b0;
      alert_oe   <= 1'b0;
      alert_out  <= 1'b0;
    end else begin
      alert_out  <= 1'b0;
      over_flag  <= (over_flag & ~status_clr) | (conv_done & over_now);
      under_flag <= (under_flag & ~status_clr) | (conv_done & under_now);
      alert_oe   <= (alert_oe & ~status_clr) | (conv_done & (over_now | under_now));
    end
  end

  // ==========================================================
  // checks
  a_busy_cont_zero:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      ctrl[CTRL_RUN_BIT] && mode != M_SINGLE |=> mode != M_SINGLE)
    else $error("busy set in continuous mode");
  a_busy_clear_result:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      mode == M_SINGLE && conv_done |=> mode == M_OFF
        && (temp == $past(sense_data) || $past(ctrl[CTRL_HOLD_BIT] && hold_lock)))
    else $error("busy did not clear with result");
  a_off_holds_data:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      mode == M_OFF |=> $stable(temp))
    else $error("data changed in power-down");
  a_off_no_conv:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      !ctrl[CTRL_RUN_BIT] && !ctrl[CTRL_TRIG_BIT] && mode != M_SINGLE
        |-> !conv_done ##1 mode == M_OFF ##1 !chain_enable)
    else $error("conversion in power-down");
  a_id_read_value:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      rd_pulse && rd_addr == ADDR_ID |-> tx == ID_VALUE)
    else $error("wrong identity byte");
  a_status_releases:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      status_clr && !conv_done |=> !alert_oe && !over_flag && !under_flag)
    else $error("status read did not release alert");
  a_alert_sticky:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      alert_oe && !status_clr |=> alert_oe)
    else $error("alert dropped without status read");
  a_limits_disabled:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      conv_done && hi_lim == 8'h00 && lo_lim == 8'h00 |=> !$rose(alert_oe))
    else $error("alert raised with limits disabled");
  a_reset_off:
    assert property (@(posedge core_clk) !rst_n |=> mode == M_OFF && !chain_enable)
    else $error("not in power-down after reset");
  a_single_once:
    assert property (@(posedge core_clk) disable iff (!rst_n)
      mode == M_SINGLE && conv_done && !(wr_pulse && wr_addr == ADDR_CTRL)
        |=> mode == M_OFF && !ctrl[CTRL_TRIG_BIT])
    else $error("single conversion left to wrong mode");
endmodule
